// ### rtl/i2c_ctrl.sv
// Purpose: Two-wire bus master/slave byte engine with status, data,
//          control, own-address and divider registers on AXI4-Lite.
// Assumes: Open-drain pins resolved outside; 25 MHz system clock.
// Notes:   SCL is held low while waiting for software between bytes.
`timescale 1ns/1ps
module i2c_ctrl
  import i2c_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_irq
);
  // Elaboration check: the decoder slices the low eight address bits
  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_aw
      $error("ADDR_W must be 8 to 32");
    end
  endgenerate

  i2c_line_if ln ();
  i2c_line_mon u_mon (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ln(ln)
  );

  // Bus slave state
  logic aw_full_q;            // Write address held
  logic w_full_q;             // Write data held
  logic [7:0] waddr_q;        // Held write address
  logic [7:0] wdat_q;         // Held write data, low byte
  logic wlane_q;              // Low byte lane enabled
  logic wr_fire;              // Write performed this cycle
  logic rd_fire;              // Read performed this cycle
  logic [7:0] raddr;          // Read address low bits
  // Registers
  logic [7:0] own_q;          // Own address in bits 7:1
  logic [7:0] div_q;          // Half SCL period in clocks, less one
  logic en_q, ie_q, mst_q, tx_q, txak_q;
  logic done_f_q, addressed_as_slave_flag_f_q, busy_f_q, arbitration_lost_flag_f_q, srw_f_q, pend_f_q, received_ack_flag_f_q;
  logic [7:0] rx_q;           // Last received byte
  // Engine state
  logic live_q;               // Tracking a byte on the bus
  logic first_q;              // Byte after START
  logic addr_q;               // Addressed as slave
  logic wait_q;               // Byte done, awaiting software
  logic [3:0] cnt_q;          // Rising SCL edges in this byte
  logic [7:0] sh_q;           // Shift register
  logic sda_low_q;            // Pull SDA low
  mstate_e ms_q;              // Master sequencer
  logic [7:0] hcnt_q;         // Half period timer
  // Decoded events
  logic ctrl_wr, stat_wr, data_wr, data_rd;
  logic start_req, stop_req, rsta_req;
  logic we_tx, party, go_tx, go_rx;
  logic rise, fall, lost, match, done, tick, scl_drive;

  // Decode of accesses and their side effects
  assign wr_fire = aw_full_q & w_full_q & ~o_bvalid;
  assign rd_fire = i_arvalid & o_arready;
  assign raddr = i_araddr[7:0];
  assign ctrl_wr = wr_fire & wlane_q & (waddr_q == OFS_CTRL);
  assign stat_wr = wr_fire & wlane_q & (waddr_q == OFS_STAT);
  assign data_wr = wr_fire & wlane_q & (waddr_q == OFS_DATA);
  assign data_rd = rd_fire & (raddr == OFS_DATA);
  assign start_req = ctrl_wr & wdat_q[CT_MST] & ~mst_q & en_q;
  assign stop_req = ctrl_wr & ~wdat_q[CT_MST] & mst_q;
  assign rsta_req = ctrl_wr & wdat_q[CT_RSTA] & en_q;

  // Direction we drive: master address byte is always transmit
  assign we_tx = mst_q ? (first_q | tx_q) : (addr_q & ~first_q & tx_q);
  assign party = mst_q | addr_q;
  assign go_tx = data_wr & wait_q & party & (tx_q | (mst_q & first_q));
  assign go_rx = data_rd & wait_q & party & ~tx_q & ~first_q;
  assign rise = ln.scl_rise & live_q;
  assign fall = ln.scl_fall & live_q;
  // Drove a one, saw a zero: data bits or our NACK slot
  assign lost = rise & mst_q & ~sda_low_q & ~ln.sda &
                ((we_tx & cnt_q <= CNT_LAST) | (~we_tx & cnt_q == CNT_ACK));
  assign match = rise & ~mst_q & first_q & (cnt_q == CNT_LAST) &
                 (sh_q[6:0] == own_q[7:1]);
  assign done = fall & (cnt_q == CNT_DONE);
  assign tick = (hcnt_q >= div_q) & (hcnt_q >= HALF_MIN);

  // Write address and data channels, taken in either order
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      waddr_q <= 8'h00;
      wdat_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_full_q <= 1'b1;
        o_awready <= 1'b0;
        waddr_q <= i_awaddr[7:0];
      end
      if (i_wvalid & o_wready) begin
        w_full_q <= 1'b1;
        o_wready <= 1'b0;
        wdat_q <= i_wdata[7:0];
        wlane_q <= i_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      // Channels reopen once the response is taken
      if (o_bvalid & i_bready) begin
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= (waddr_q == OFS_ADDR || waddr_q == OFS_DIV ||
                  waddr_q == OFS_CTRL || waddr_q == OFS_STAT ||
                  waddr_q == OFS_DATA) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Read channel, data captured at the address handshake
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      unique case (raddr)
        OFS_ADDR: o_rdata <= {24'h000000, own_q[7:1], 1'b0};
        OFS_DIV: o_rdata <= {24'h000000, div_q};
        OFS_CTRL: o_rdata <= {24'h000000, en_q, ie_q, mst_q, tx_q,
                              txak_q, 3'h0};
        OFS_STAT: o_rdata <= {24'h000000, done_f_q, addressed_as_slave_flag_f_q, busy_f_q,
                              arbitration_lost_flag_f_q, 1'b0, srw_f_q, pend_f_q,
                              received_ack_flag_f_q};
        OFS_DATA: o_rdata <= {24'h000000, rx_q};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Own address and divider registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      own_q <= ADDR_RST;
      div_q <= DIV_RST;
    end else begin
      if (wr_fire & wlane_q & (waddr_q == OFS_ADDR)) begin
        own_q <= wdat_q;
      end
      if (wr_fire & wlane_q & (waddr_q == OFS_DIV)) begin
        div_q <= wdat_q;
      end
    end
  end

  // Control register; hardware drops master select on a lost bus
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {en_q, ie_q, mst_q, tx_q, txak_q} <= CTRL_RST[7:3];
    end else begin
      if (ctrl_wr) begin
        en_q <= wdat_q[CT_EN];
        ie_q <= wdat_q[CT_IE];
        mst_q <= wdat_q[CT_MST] & wdat_q[CT_EN];
        tx_q <= wdat_q[CT_TX];
        txak_q <= wdat_q[CT_TXAK];
      end
      // Busy bus or loss forces slave mode
      if (lost | (start_req & busy_f_q)) begin
        mst_q <= 1'b0;
      end
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_f_q <= 1'b0;
      addressed_as_slave_flag_f_q <= 1'b0;
      busy_f_q <= 1'b0;
      arbitration_lost_flag_f_q <= 1'b0;
      srw_f_q <= 1'b0;
      pend_f_q <= 1'b0;
      received_ack_flag_f_q <= 1'b0;
    end else begin
      // Clears by software
      if (go_tx | go_rx) done_f_q <= 1'b0;
      if (ctrl_wr) addressed_as_slave_flag_f_q <= 1'b0;
      if (stat_wr & wdat_q[ST_ARBITRATION_LOST_FLAG]) arbitration_lost_flag_f_q <= 1'b0;
      if (stat_wr & wdat_q[ST_PEND]) pend_f_q <= 1'b0;
      // Sets by hardware
      if (done) done_f_q <= 1'b1;
      if (match) begin
        addressed_as_slave_flag_f_q <= 1'b1;
        srw_f_q <= ln.sda;
      end
      if (lost | (start_req & busy_f_q) | (rsta_req & ~mst_q)) begin
        arbitration_lost_flag_f_q <= 1'b1;
      end
      if (done | match | lost | (start_req & busy_f_q) |
          (rsta_req & ~mst_q)) begin
        pend_f_q <= 1'b1;
      end
      if (rise & we_tx & (cnt_q == CNT_ACK)) begin
        received_ack_flag_f_q <= ln.sda;
      end
      if (ln.start_det) busy_f_q <= 1'b1;
      if (ln.stop_det) busy_f_q <= 1'b0;
    end
  end

  // Byte tracking: bit count, shift, address and wait state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      live_q <= 1'b0;
      first_q <= 1'b0;
      addr_q <= 1'b0;
      wait_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
    end else if (!en_q | ln.stop_det) begin
      live_q <= 1'b0;
      first_q <= 1'b0;
      addr_q <= 1'b0;
      wait_q <= 1'b0;
      cnt_q <= CNT_ZERO;
    end else if (ln.start_det) begin
      // Master waits for its address byte; others listen
      live_q <= 1'b1;
      first_q <= 1'b1;
      addr_q <= 1'b0;
      wait_q <= mst_q;
      cnt_q <= CNT_ZERO;
    end else begin
      if (go_tx) begin
        sh_q <= wdat_q;
        wait_q <= 1'b0;
      end
      if (go_rx) wait_q <= 1'b0;
      if (lost) wait_q <= 1'b0;
      if (match) addr_q <= 1'b1;
      if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q <= CNT_LAST) sh_q <= {sh_q[6:0], ln.sda};
      end
      if (done) begin
        cnt_q <= CNT_ZERO;
        first_q <= 1'b0;
        if (!we_tx) rx_q <= sh_q;
        if (mst_q) begin
          wait_q <= 1'b1;
        end else if (addr_q & ~(we_tx & received_ack_flag_f_q)) begin
          wait_q <= 1'b1;
        end else begin
          // Not ours, or master refused further bytes
          live_q <= 1'b0;
          addr_q <= 1'b0;
        end
      end
    end
  end

  // SDA drive: start and stop edges, data bits, acknowledge slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sda_low_q <= 1'b0;
    end else if (!en_q | lost) begin
      sda_low_q <= 1'b0;
    end else if (ms_q == M_IDLE & start_req & ~busy_f_q) begin
      sda_low_q <= 1'b1;
    end else if (ms_q == M_LOW & wait_q & stop_req) begin
      sda_low_q <= 1'b1;
    end else if (ms_q == M_LOW & wait_q & rsta_req) begin
      sda_low_q <= 1'b0;
    end else if (ms_q == M_STOP2 & ln.scl & tick) begin
      sda_low_q <= 1'b0;
    end else if (ms_q == M_RS2 & ln.scl & tick) begin
      sda_low_q <= 1'b1;
    end else if (go_tx) begin
      sda_low_q <= ~wdat_q[7];
    end else if (go_rx) begin
      sda_low_q <= 1'b0;
    end else if (fall) begin
      if (cnt_q != CNT_ZERO & cnt_q <= CNT_LAST) begin
        sda_low_q <= we_tx & ~sh_q[7];
      end else if (cnt_q == CNT_ACK) begin
        if (we_tx) begin
          sda_low_q <= 1'b0;
        end else if (~mst_q & first_q) begin
          sda_low_q <= addr_q;
        end else begin
          sda_low_q <= party & ~txak_q;
        end
      end else if (cnt_q != CNT_ZERO) begin
        // START fall keeps SDA low until the address byte is loaded
        sda_low_q <= 1'b0;
      end
    end
  end

  // Master sequencer for START, clocking, STOP and repeated START
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ms_q <= M_IDLE;
    end else if (!en_q | lost) begin
      ms_q <= M_IDLE;
    end else begin
      unique case (ms_q)
        M_IDLE: if (start_req & ~busy_f_q) ms_q <= M_START;
        M_START: if (tick) ms_q <= M_LOW;
        M_LOW: begin
          if (wait_q & stop_req) begin
            ms_q <= M_STOP1;
          end else if (wait_q & rsta_req) begin
            ms_q <= M_RS1;
          end else if (tick & ~wait_q) begin
            ms_q <= M_HIGH;
          end
        end
        M_HIGH: if (ln.scl & tick) ms_q <= M_LOW;
        M_STOP1: if (tick) ms_q <= M_STOP2;
        M_STOP2: if (ln.scl & tick) ms_q <= M_IDLE;
        M_RS1: if (tick) ms_q <= M_RS2;
        M_RS2: if (ln.scl & tick) ms_q <= M_START;
      endcase
    end
  end

  // Half period timer; high phases count only once SCL reads high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hcnt_q <= 8'h00;
    end else if (ms_q == M_IDLE | tick) begin
      hcnt_q <= 8'h00;
    end else if (!(ms_q == M_HIGH | ms_q == M_STOP2 | ms_q == M_RS2) |
                 ln.scl) begin
      hcnt_q <= hcnt_q + 8'h01;
    end
  end

  // Master low phases, or slave stretch while software is busy
  assign scl_drive = ms_q == M_LOW | ms_q == M_STOP1 | ms_q == M_RS1 |
                     (~mst_q & addr_q & wait_q);

  // Pin and interrupt outputs, all registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
      o_irq <= 1'b0;
    end else begin
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      o_scl_oe_n <= ~scl_drive;
      o_sda_oe_n <= ~sda_low_q;
      o_irq <= pend_f_q & ie_q;
    end
  end
endmodule

// ### rtl/i2c_pkg.sv
// Purpose: Constants, register map and state codes of the two-wire
//          bus controller with status flags and data register.
// Assumes: 32-bit AXI4-Lite register access, 8-bit registers in low bits.
// Notes:   Rules carried by the byte engine follow.
// Operation
// - Byte done sets flag; data access clears
// - Own address match sets flag; control write clears
// - START sets bus-occupied, STOP clears it
// - Arbitration loss sets flag; write one clears
// - Slave direction flag holds received R/W bit
// - Pending flag on byte, match, loss
// - Sampled acknowledge recorded after transmitted byte
// - Master data write sends byte MSB first
// - Master data read starts next byte reception
// - Data access triggers only matching direction
// - Addressed slave uses same data triggering
// - Data read returns last received byte
// - First byte after master start is address
// - START only on free bus, SDA falls
// - First byte: seven-bit address plus direction
// - Only matching slave acknowledges ninth clock
// - Never master and slave; fall back
// - Eight bits MSB first, ninth ack clock
// - Missing acknowledge leaves SDA high, fails
// - Master NACK ends slave transmit, release
// - After NACK master stops or restarts
// - STOP: SDA rises while SCL high
// - Interrupt from pending flag gated by enable
package i2c_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  // Status field positions
  localparam int ST_DONE = 7;
  localparam int ST_ADDRESSED_AS_SLAVE_FLAG = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_ARBITRATION_LOST_FLAG = 4;
  localparam int ST_SRW = 2;
  localparam int ST_PEND = 1;
  localparam int ST_RECEIVED_ACK_FLAG = 0;
  // Control field positions
  localparam int CT_EN = 7;
  localparam int CT_IE = 6;
  localparam int CT_MST = 5;
  localparam int CT_TX = 4;
  localparam int CT_TXAK = 3;
  localparam int CT_RSTA = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h32;
  // Smallest divider value (half SCL period in clocks, less one) the engine can serve
  localparam logic [7:0] HALF_MIN = 8'h04;
  // Bit counter marks (rising SCL edges seen in one byte)
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Master sequencer states
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_LOW   = 3'b010,
    M_HIGH  = 3'b011,
    M_STOP1 = 3'b100,
    M_STOP2 = 3'b101,
    M_RS1   = 3'b110,
    M_RS2   = 3'b111
  } mstate_e;
endpackage

// ### rtl/i2c_line_if.sv
// Purpose: Carries synchronised bus levels and line events.
// Assumes: All signals on the system clock.
// Notes:   Events are one-cycle pulses.
`timescale 1ns/1ps
interface i2c_line_if;
  logic scl;       // Synchronised SCL level
  logic sda;       // Synchronised SDA level
  logic scl_rise;  // SCL went high
  logic scl_fall;  // SCL went low
  logic start_det; // SDA fell while SCL high
  logic stop_det;  // SDA rose while SCL high
  modport mon (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport eng (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// ### rtl/i2c_line_mon.sv
// Purpose: Synchronises SCL and SDA and finds edges, START and STOP.
// Assumes: Pins are asynchronous to i_clk.
// Notes:   Two flip-flops before any logic; third stage for edges.
`timescale 1ns/1ps
module i2c_line_mon (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  i2c_line_if.mon ln
);
  logic scl_m_q; // First sync stage, SCL
  logic sda_m_q; // First sync stage, SDA
  logic scl_s_q; // Second sync stage, SCL
  logic sda_s_q; // Second sync stage, SDA
  logic scl_p_q; // Previous synchronised SCL
  logic sda_p_q; // Previous synchronised SDA

  // Synchroniser chain, idle bus reads high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      sda_m_q <= i_sda;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Levels and events from the second and third stages only
  assign ln.scl = scl_s_q;
  assign ln.sda = sda_s_q;
  assign ln.scl_rise = scl_s_q & ~scl_p_q;
  assign ln.scl_fall = ~scl_s_q & scl_p_q;
  assign ln.start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign ln.stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
endmodule

// ### dv/i2c_ctrl_asserts.sv
// Purpose: Port-level checks of the two-wire bus controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every controller instance.
`timescale 1ns/1ps
module i2c_ctrl_asserts
  import i2c_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe_n,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic o_irq
);
  logic [ADDR_W-1:0] aw_q; // Last write address taken
  logic [7:0] wd_q; // Last write data byte taken
  logic bv_q; // Response was up last cycle
  logic ie_q; // Shadow of the interrupt enable bit
  // Follow writes so the enable shadow tracks control updates
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_q <= '0;
      wd_q <= 8'h00;
      bv_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) aw_q <= i_awaddr;
      if (i_wvalid && o_wready) wd_q <= i_wdata[7:0];
      bv_q <= o_bvalid;
      if (o_bvalid && !bv_q && aw_q[7:0] == OFS_CTRL) ie_q <= wd_q[CT_IE];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  reset_idle_a: assert property ($rose(i_rst_n) |-> o_sda_oe_n &&
    o_scl_oe_n && !o_irq && !o_bvalid && !o_rvalid)
    else $error("outputs not idle after reset");
  write_answer_a: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |=> !o_bvalid ##1 o_bvalid)
    else $error("write response late or early");
  write_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid &&
    o_rdata[31:8] == 24'h0)
    else $error("read answer missing or wide");
  resp_map_a: assert property (o_bvalid && aw_q[1:0] == 2'h0 |->
    o_bresp == ((aw_q[7:0] > OFS_DATA) ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong write response code");
  start_cond_a: assert property ($fell(o_sda_oe_n) && o_scl_oe_n && i_scl
    |-> ##[1:260] !o_scl_oe_n)
    else $error("clock not pulled after start");
  stop_cond_a: assert property ($rose(o_sda_oe_n) && i_scl &&
    $past(i_scl, 3) |=> o_scl_oe_n [*8])
    else $error("clock driven after stop");
  irq_gate_a: assert property (!ie_q && !$past(ie_q) |-> !o_irq)
    else $error("interrupt while disabled");
  pins_low_a: assert property (!o_scl && !o_sda)
    else $error("open-drain pin data not low");
  cover property (o_bvalid && o_bresp == RESP_SLVERR);
  cover property ($fell(o_sda_oe_n) && i_scl);
  cover property ($rose(o_irq));
endmodule
bind i2c_ctrl i2c_ctrl_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);

// ### dv/i2c_bus_model.sv
// Purpose: Behavioural target on the two-wire bus.
// Assumes: Open-drain lines; released means pulled high.
// Notes:   Optional clock stretch in the acknowledge slot.
`timescale 1ns/1ps
module i2c_bus_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] RD_BYTE = 8'hC3
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_slow,
  output logic o_scl_rel,
  output logic o_sda_rel,
  output logic [7:0] o_last
);
  logic [7:0] b; // Shift register for incoming bits
  // Eight rising clocks, first bit is the top one
  task automatic get_byte;
    repeat (8) begin
      @(posedge i_scl);
      b = {b[6:0], i_sda};
    end
  endtask
  // Pull data low for the ninth clock, stretch it when slow
  task automatic ack_slot;
    @(negedge i_scl);
    #4 o_sda_rel = 1'b0;
    if (i_slow) begin
      o_scl_rel = 1'b0;
      #400 o_scl_rel = 1'b1;
    end
    @(negedge i_scl);
    #4 o_sda_rel = 1'b1;
  endtask
  // One addressed session up to the next stop
  task automatic session;
    get_byte();
    if (b[7:1] !== ADDR) wait (1'b0);
    ack_slot();
    if (b[0]) begin
      forever begin
        for (int i = 7; i >= 0; i--) begin
          o_sda_rel = RD_BYTE[i];
          @(negedge i_scl);
          #4;
        end
        o_sda_rel = 1'b1;
        @(posedge i_scl);
        if (i_sda) wait (1'b0);
        @(negedge i_scl);
        #4;
      end
    end else begin
      forever begin
        get_byte();
        o_last = b;
        ack_slot();
      end
    end
  endtask
  // Sessions open at start and are dropped at stop
  initial begin
    o_sda_rel = 1'b1;
    o_scl_rel = 1'b1;
    o_last = 8'h00;
    forever begin
      @(negedge i_sda iff i_scl === 1'b1);
      fork
        session();
        @(posedge i_sda iff i_scl === 1'b1);
      join_any
      disable fork;
      o_sda_rel = 1'b1;
      o_scl_rel = 1'b1;
    end
  end
endmodule

// ### dv/tb.sv
// Purpose: Register-level tests of the bus controller.
// Assumes: Target model on the wire, half-period of 200 ns.
// Notes:   Ends through the results task.
`timescale 1ns/1ps
module tb;
  import i2c_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n;
  logic [7:0] i_awaddr, i_araddr, s;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, resp;
  logic i_scl, i_sda, o_scl, o_sda, o_scl_oe_n, o_sda_oe_n;
  logic scl_rel, sda_rel, slow;
  logic [7:0] last_byte;
  int bad_count, samples_checked, cyc;
  localparam logic [6:0] TGT = 7'h2A;
  localparam logic [7:0] RD_BYTE = 8'hC3;
  logic [7:0] ofs_t [6] = '{OFS_ADDR, OFS_DIV, OFS_CTRL, OFS_STAT,
    OFS_DATA, 8'h14};
  logic [7:0] rst_t [6] = '{8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
  // Wired-AND lines with pull-ups
  assign i_scl = (o_scl_oe_n | o_scl) & scl_rel;
  assign i_sda = (o_sda_oe_n | o_sda) & sda_rel;
  always #20 i_clk = ~i_clk;
  i2c_ctrl #(.ADDR_W(8)) dut_u (.*);
  i2c_bus_model #(.ADDR(TGT), .RD_BYTE(RD_BYTE)) peer_u (.i_scl(i_scl),
    .i_sda(i_sda), .i_slow(slow), .o_scl_rel(scl_rel),
    .o_sda_rel(sda_rel), .o_last(last_byte));
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  // One write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      resp = o_bresp;
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
  endtask
  // One read, low byte lands in s
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      s = o_rdata[7:0];
      resp = o_rresp;
    end while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
  endtask
  // Poll status until a bit reaches a level
  task automatic poll(input int b, input logic v);
    for (int k = 0; k < 400; k++) begin
      rd(OFS_STAT);
      if (s[b] === v) break;
    end
  endtask
  // Start, send the address byte, wait for its end
  task automatic start_addr(input logic [7:0] ab);
    wr(OFS_CTRL, 8'hF0);
    poll(ST_BUSY, 1'b1);
    chk("busy at start", 1, s[ST_BUSY]);
    wr(OFS_DATA, ab);
    rd(OFS_STAT);
    chk("done cleared", 0, s[ST_DONE]);
    poll(ST_DONE, 1'b1);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    {i_awaddr, i_araddr, i_wdata} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_wstrb = 4'hF;
    i_rst_n = 1'b0;
    slow = 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(ofs_t[k]);
      chk("reset value", rst_t[k], s);
    end
    chk("unmapped read response", RESP_SLVERR, resp);
    wr(8'h14, 8'hFF);
    chk("unmapped response", RESP_SLVERR, resp);
    wr(OFS_ADDR, 8'h55);
    rd(OFS_ADDR);
    chk("own address", 8'h54, s);
    wr(OFS_DIV, 8'h04);
    wr(OFS_CTRL, 8'h80);
    $display("test registers done");
    start_addr({TGT, 1'b0});
    rd(OFS_STAT);
    chk("status after address", 8'hA2, s);
    chk("irq raised", 1, o_irq);
    wr(OFS_STAT, 8'h02);
    rd(OFS_STAT);
    chk("pending cleared", 8'hA0, s);
    chk("irq cleared", 0, o_irq);
    wr(OFS_DATA, 8'hA5);
    poll(ST_DONE, 1'b1);
    chk("byte on wire", 8'hA5, last_byte);
    wr(OFS_CTRL, 8'hB0);
    rd(OFS_STAT);
    chk("pending kept", 1, s[ST_PEND]);
    chk("irq masked", 0, o_irq);
    wr(OFS_CTRL, 8'h80);
    poll(ST_BUSY, 1'b0);
    chk("bus free", 0, s[ST_BUSY]);
    $display("test master write done");
    slow = 1'b0;
    start_addr({7'h13, 1'b0});
    rd(OFS_STAT);
    chk("no acknowledge", 1, s[ST_RECEIVED_ACK_FLAG]);
    wr(OFS_CTRL, 8'h80);
    poll(ST_BUSY, 1'b0);
    chk("stop after nack", 0, s[ST_BUSY]);
    $display("test nack done");
    start_addr({TGT, 1'b1});
    rd(OFS_STAT);
    chk("read address ack", 0, s[ST_RECEIVED_ACK_FLAG]);
    rd(OFS_DATA);
    rd(OFS_STAT);
    chk("wrong direction", 1, s[ST_DONE]);
    wr(OFS_CTRL, 8'hA8);
    rd(OFS_DATA);
    rd(OFS_STAT);
    chk("receive started", 0, s[ST_DONE]);
    poll(ST_DONE, 1'b1);
    wr(OFS_CTRL, 8'h80);
    rd(OFS_DATA);
    chk("received byte", RD_BYTE, s);
    poll(ST_BUSY, 1'b0);
    $display("test master read done");
    results();
  end
endmodule
